/* File: hw/select_unit_regs.vh */
// Encodings, field positions and widths for the select and sign-extend unit
`ifndef SELECT_UNIT_REGS_VH
`define SELECT_UNIT_REGS_VH

// Operand width
`define SU_GPR_WIDTH      64
`define SU_FPR_WIDTH      64
`define SU_WORD_WIDTH     32

// Operation codes on OP_CODE
`define SU_OP_WIDTH       3
`define SU_OP_SIGN_EXT_HALF 3'h0
`define SU_OP_FP_BIT_SEL  3'h1
`define SU_OP_INT_SEL_EQZ 3'h2
`define SU_OP_INT_SEL_NEZ 3'h3
`define SU_OP_FP_SEL_EQZ  3'h4
`define SU_OP_FP_SEL_NEZ  3'h5

// Floating-point format field
`define SU_FMT_WIDTH      2
`define SU_FMT_SINGLE     2'h0
`define SU_FMT_DOUBLE     2'h1

// Architecture release field
`define SU_REL_WIDTH      4
`define SU_REL_SIGN_EXT   4'h2
`define SU_REL_SELECTS    4'h6

// Halfword sign bit and condition bit positions
`define SU_HALF_MSB       15
`define SU_COND_BIT       0

// Exception codes on EXC_CODE
`define SU_EXC_WIDTH      2
`define SU_EXC_NONE       2'h0
`define SU_EXC_RESERVED   2'h1
`define SU_EXC_COP_UNUSE  2'h2

`endif

/* File: hw/int_select.v */
// Integer select-or-zero datapath
`include "select_unit_regs.vh"

module int_select
(
  // Operands
  input  wire [`SU_GPR_WIDTH-1:0] cond_value,
  input  wire [`SU_GPR_WIDTH-1:0] data_value,
  input  wire                     select_if_nonzero,
  input  wire                     is_64bit_core,
  // Result
  output reg  [`SU_GPR_WIDTH-1:0] result
);

  reg cond_nonzero;
  reg cond_true;

  always @*
  begin
    // A 32-bit core tests only its 32 register bits
    if (is_64bit_core)
      cond_nonzero = |cond_value; // [RQ12]
    else
      cond_nonzero = |cond_value[`SU_WORD_WIDTH-1:0]; // [RQ12]
    cond_true = select_if_nonzero ? cond_nonzero : ~cond_nonzero; // [RQ10] [RQ11]
    result = cond_true ? data_value : {`SU_GPR_WIDTH{1'b0}}; // [RQ10] [RQ11] [RQ12]
  end

endmodule // int_select

/* File: hw/fp_select.v */
// Floating-point bit-select and select-or-zero datapath
`include "select_unit_regs.vh"

module fp_select
(
  // Operands
  input  wire [`SU_FPR_WIDTH-1:0] cond_value,
  input  wire [`SU_FPR_WIDTH-1:0] true_value,
  input  wire [`SU_FPR_WIDTH-1:0] false_value,
  input  wire                     bit_select,
  input  wire                     select_if_nonzero,
  input  wire                     double_fmt,
  // Result
  output reg  [`SU_FPR_WIDTH-1:0] result
);

  reg                     cond_true;
  reg [`SU_FPR_WIDTH-1:0] picked;

  always @*
  begin
    // Only bit 0 of the condition register matters
    if (bit_select)
      cond_true = cond_value[`SU_COND_BIT]; // [RQ4]
    else if (select_if_nonzero)
      cond_true = cond_value[`SU_COND_BIT]; // [RQ14]
    else
      cond_true = ~cond_value[`SU_COND_BIT]; // [RQ13]
    if (bit_select)
      picked = cond_true ? true_value : false_value; // [RQ5]
    else
      picked = cond_true ? true_value : {`SU_FPR_WIDTH{1'b0}}; // [RQ13] [RQ14] [RQ15]
    // Format sets width only; upper bits of single cleared
    if (double_fmt)
      result = picked; // [RQ6] [RQ17]
    else
      result = {{(`SU_FPR_WIDTH-`SU_WORD_WIDTH){1'b0}}, picked[`SU_WORD_WIDTH-1:0]}; // [RQ6] [RQ17]
  end

endmodule // fp_select

/* File: hw/select_sign_extend_unit.v */
// Select and halfword sign-extend execution unit, registered result
// Operation
// [RQ1] Before release 2, halfword sign-extend raises Reserved Instruction.
// [RQ2] Source not a sign-extended word gives an unpredictable result.
// [RQ3] Halfword sign-extend replicates source bit 15 through all upper bits.
// [RQ4] Bit-select condition is bit 0 of prior destination only.
// [RQ5] Bit-select writes true operand if bit set, false operand otherwise.
// [RQ6] Single and double formats set width only; data passes unchanged.
// [RQ7] Bit-select raises no data exception and leaves cause flags alone.
// [RQ8] Only single and double formats valid; others raise Reserved Instruction.
// [RQ9] Bit-select raises Coprocessor Unusable when FP access disabled.
// [RQ10] Integer select-if-zero passes data when condition register is all zero.
// [RQ11] Integer select-if-nonzero passes data when any condition bit is set.
// [RQ12] Integer selects test and pass all general register bits.
// [RQ13] FP select-if-zero passes data when condition bit 0 is clear.
// [RQ14] FP select-if-nonzero passes data when condition bit 0 is set.
// [RQ15] FP select-or-zero writes all zero when condition is false.
// [RQ16] FP select-or-zero raises no execution exception, cause flags unchanged.
// [RQ17] Only bits within the format width are defined in FP results.
// [RQ18] FP selects are decoded and executed on release 6 and later.
`include "select_unit_regs.vh"

module select_sign_extend_unit
(
  // Clock and reset
  input  wire                       REF_CLK,
  input  wire                       RST,
  // Core configuration
  input  wire [`SU_REL_WIDTH-1:0]   ARCH_RELEASE,
  input  wire                       CORE_64BIT,
  input  wire                       FP_ENABLED,
  // Issue
  input  wire                       ISSUE_VALID,
  input  wire [`SU_OP_WIDTH-1:0]    OP_CODE,
  input  wire [`SU_FMT_WIDTH-1:0]   FP_FMT,
  input  wire [4:0]                 DEST_INDEX,
  // General register operands
  input  wire [`SU_GPR_WIDTH-1:0]   DATA_SRC_REGISTER,
  input  wire [`SU_GPR_WIDTH-1:0]   SECOND_GPR_FIELD,
  // Floating-point operands
  input  wire [`SU_FPR_WIDTH-1:0]   FP_COND_FIELD,
  input  wire [`SU_FPR_WIDTH-1:0]   FP_DATA_FIELD,
  input  wire [`SU_FPR_WIDTH-1:0]   FP_DEST_FIELD,
  // Results
  output reg                        GPR_WRITE,
  output reg                        FPR_WRITE,
  output reg  [4:0]                 WRITE_INDEX,
  output reg  [`SU_GPR_WIDTH-1:0]   WRITE_DATA,
  output reg                        FP_CAUSE_WRITE,
  // Exceptions
  output reg                        EXC_VALID,
  output reg  [`SU_EXC_WIDTH-1:0]   EXC_CODE
);

  function [`SU_GPR_WIDTH-1:0] fit_core;
    input [`SU_GPR_WIDTH-1:0] value;
    input                     wide;
    begin
      if (wide)
        fit_core = value;
      else
        fit_core = {{(`SU_GPR_WIDTH-`SU_WORD_WIDTH){value[`SU_WORD_WIDTH-1]}}, value[`SU_WORD_WIDTH-1:0]};
    end
  endfunction

  wire [`SU_GPR_WIDTH-1:0] int_result;
  wire [`SU_FPR_WIDTH-1:0] fp_result;
  wire                     is_bit_sel;
  wire                     fmt_ok;
  wire                     rel6;
  wire [`SU_FPR_WIDTH-1:0] fp_true_in;
  wire [`SU_FPR_WIDTH-1:0] fp_cond_in;

  reg                      gpr_write_nxt;
  reg                      fpr_write_nxt;
  reg [`SU_GPR_WIDTH-1:0]  data_nxt;
  reg                      exc_nxt;
  reg [`SU_EXC_WIDTH-1:0]  code_nxt;

  assign is_bit_sel     = (OP_CODE == `SU_OP_FP_BIT_SEL);
  assign fmt_ok         = (FP_FMT == `SU_FMT_SINGLE) || (FP_FMT == `SU_FMT_DOUBLE); // [RQ8]
  assign rel6           = (ARCH_RELEASE >= `SU_REL_SELECTS); // [RQ18]
  // Bit-select: condition in old destination, true operand in cond field
  assign fp_cond_in     = is_bit_sel ? FP_DEST_FIELD : FP_COND_FIELD; // [RQ4]
  assign fp_true_in     = is_bit_sel ? FP_COND_FIELD : FP_DATA_FIELD; // [RQ5]

  int_select u_int_select
  (
    .cond_value        (SECOND_GPR_FIELD),
    .data_value        (DATA_SRC_REGISTER),
    .select_if_nonzero (OP_CODE == `SU_OP_INT_SEL_NEZ),
    .is_64bit_core     (CORE_64BIT),
    .result            (int_result)
  );

  fp_select u_fp_select
  (
    .cond_value        (fp_cond_in),
    .true_value        (fp_true_in),
    .false_value       (FP_DATA_FIELD),
    .bit_select        (is_bit_sel),
    .select_if_nonzero (OP_CODE == `SU_OP_FP_SEL_NEZ),
    .double_fmt        (FP_FMT == `SU_FMT_DOUBLE),
    .result            (fp_result)
  );

  always @*
  begin
    gpr_write_nxt = 1'b0;
    fpr_write_nxt = 1'b0;
    data_nxt      = {`SU_GPR_WIDTH{1'b0}};
    exc_nxt       = 1'b0;
    code_nxt      = `SU_EXC_NONE;
    if (ISSUE_VALID)
    begin
      case (OP_CODE)
        `SU_OP_SIGN_EXT_HALF:
        begin
          if (ARCH_RELEASE < `SU_REL_SIGN_EXT)
          begin
            exc_nxt  = 1'b1; // [RQ1]
            code_nxt = `SU_EXC_RESERVED; // [RQ1]
          end
          else
          begin
            // Non-word source is not checked; result follows low half anyway
            gpr_write_nxt = 1'b1; // [RQ2]
            data_nxt = fit_core({{(`SU_GPR_WIDTH-`SU_HALF_MSB-1){DATA_SRC_REGISTER[`SU_HALF_MSB]}},
                                 DATA_SRC_REGISTER[`SU_HALF_MSB:0]}, CORE_64BIT); // [RQ3]
          end
        end
        `SU_OP_INT_SEL_EQZ, `SU_OP_INT_SEL_NEZ:
        begin
          if (!rel6)
          begin
            exc_nxt  = 1'b1;
            code_nxt = `SU_EXC_RESERVED;
          end
          else
          begin
            gpr_write_nxt = 1'b1; // [RQ10] [RQ11]
            data_nxt      = CORE_64BIT ? int_result :
                            {{(`SU_GPR_WIDTH-`SU_WORD_WIDTH){1'b0}}, int_result[`SU_WORD_WIDTH-1:0]}; // [RQ12]
          end
        end
        `SU_OP_FP_BIT_SEL, `SU_OP_FP_SEL_EQZ, `SU_OP_FP_SEL_NEZ:
        begin
          if (!rel6 || !fmt_ok)
          begin
            exc_nxt  = 1'b1; // [RQ8] [RQ9]
            code_nxt = `SU_EXC_RESERVED; // [RQ8] [RQ9]
          end
          else if (!FP_ENABLED)
          begin
            exc_nxt  = 1'b1; // [RQ9]
            code_nxt = `SU_EXC_COP_UNUSE; // [RQ9]
          end
          else
          begin
            // Pure bit moves: never data-dependent exceptions
            fpr_write_nxt = 1'b1; // [RQ7] [RQ16] [RQ18]
            data_nxt      = fp_result; // [RQ6] [RQ17]
          end
        end
        default:
        begin
          exc_nxt  = 1'b1;
          code_nxt = `SU_EXC_RESERVED;
        end
      endcase
    end
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      GPR_WRITE      <= 1'b0;
      FPR_WRITE      <= 1'b0;
      WRITE_INDEX    <= 5'h00;
      WRITE_DATA     <= {`SU_GPR_WIDTH{1'b0}};
      FP_CAUSE_WRITE <= 1'b0;
      EXC_VALID      <= 1'b0;
      EXC_CODE       <= `SU_EXC_NONE;
    end
    else
    begin
      GPR_WRITE      <= gpr_write_nxt;
      FPR_WRITE      <= fpr_write_nxt;
      WRITE_INDEX    <= DEST_INDEX;
      WRITE_DATA     <= data_nxt;
      FP_CAUSE_WRITE <= 1'b0; // [RQ7] [RQ16]
      EXC_VALID      <= exc_nxt;
      EXC_CODE       <= code_nxt;
    end
  end

endmodule // select_sign_extend_unit

/* File: test/select_unit_checker.sv */
// Assertion checker for the select and sign-extend unit
`include "select_unit_regs.vh"

module select_unit_checker
(
  // Clock and reset
  input logic        REF_CLK,
  input logic        RST,
  // Issue
  input logic [3:0]  ARCH_RELEASE,
  input logic        CORE_64BIT,
  input logic        FP_ENABLED,
  input logic        ISSUE_VALID,
  input logic [2:0]  OP_CODE,
  input logic [1:0]  FP_FMT,
  input logic [63:0] DATA_SRC_REGISTER,
  input logic [63:0] SECOND_GPR_FIELD,
  input logic [63:0] FP_COND_FIELD,
  input logic [63:0] FP_DATA_FIELD,
  input logic [63:0] FP_DEST_FIELD,
  // Results
  input logic        GPR_WRITE,
  input logic        FPR_WRITE,
  input logic [63:0] WRITE_DATA,
  input logic        FP_CAUSE_WRITE,
  input logic        EXC_VALID,
  input logic [1:0]  EXC_CODE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire sel_ok = ISSUE_VALID && ARCH_RELEASE >= `SU_REL_SELECTS;
  wire fp_op  = OP_CODE == `SU_OP_FP_BIT_SEL || OP_CODE[2:1] == 2'h2;
  wire seh    = ISSUE_VALID && OP_CODE == `SU_OP_SIGN_EXT_HALF;
  wire bsel   = sel_ok && OP_CODE == `SU_OP_FP_BIT_SEL && FP_FMT == `SU_FMT_DOUBLE && FP_ENABLED;
  wire zsel   = sel_ok && OP_CODE[2:1] == 2'h2 && !FP_FMT[1] && FP_ENABLED;
  wire isel   = sel_ok && OP_CODE[2:1] == 2'h1;
  wire icond  = CORE_64BIT ? |SECOND_GPR_FIELD : |SECOND_GPR_FIELD[31:0];

  a_one_answer: assert property (ISSUE_VALID |=> $onehot({GPR_WRITE, FPR_WRITE, EXC_VALID}))
    else $error("issue without exactly one answer");
  a_idle_quiet: assert property (!ISSUE_VALID |=> !(GPR_WRITE || FPR_WRITE || EXC_VALID))
    else $error("answer without issue");
  a_seh_early: assert property (seh && ARCH_RELEASE < `SU_REL_SIGN_EXT |=> EXC_VALID && EXC_CODE == 2'h1)
    else $error("early sign-extend not reserved");
  a_seh_value: assert property (seh && ARCH_RELEASE >= `SU_REL_SIGN_EXT |=> GPR_WRITE &&
    WRITE_DATA == {{48{$past(DATA_SRC_REGISTER[15])}}, $past(DATA_SRC_REGISTER[15:0])})
    else $error("sign-extend result wrong");
  a_bit_pick: assert property (bsel |=> FPR_WRITE && WRITE_DATA ==
    ($past(FP_DEST_FIELD[0]) ? $past(FP_COND_FIELD) : $past(FP_DATA_FIELD)))
    else $error("bit-select picked wrong operand");
  a_zero_fill: assert property (zsel && FP_COND_FIELD[0] != OP_CODE[0] |=> FPR_WRITE && WRITE_DATA == 64'h0)
    else $error("false select not zero");
  a_bad_format: assert property (sel_ok && fp_op && FP_FMT[1] |=> EXC_VALID && EXC_CODE == 2'h1)
    else $error("bad format not reserved");
  a_fp_off: assert property (sel_ok && fp_op && !FP_FMT[1] && !FP_ENABLED |=> EXC_VALID && EXC_CODE == 2'h2)
    else $error("disabled unit not reported");
  a_cause_quiet: assert property (!FP_CAUSE_WRITE)
    else $error("cause flags written");
  a_int_zero: assert property (isel && icond != OP_CODE[0] |=> GPR_WRITE && WRITE_DATA == 64'h0)
    else $error("false integer select not zero");

  c_gpr: cover property (GPR_WRITE);
  c_fpr: cover property (FPR_WRITE);
  c_unusable: cover property (EXC_VALID && EXC_CODE == 2'h2);
endmodule // select_unit_checker

bind select_sign_extend_unit select_unit_checker select_unit_checker_i (.REF_CLK(REF_CLK), .RST(RST),
  .ARCH_RELEASE(ARCH_RELEASE), .CORE_64BIT(CORE_64BIT), .FP_ENABLED(FP_ENABLED), .ISSUE_VALID(ISSUE_VALID),
  .OP_CODE(OP_CODE), .FP_FMT(FP_FMT), .DATA_SRC_REGISTER(DATA_SRC_REGISTER),
  .SECOND_GPR_FIELD(SECOND_GPR_FIELD), .FP_COND_FIELD(FP_COND_FIELD),
  .FP_DATA_FIELD(FP_DATA_FIELD), .FP_DEST_FIELD(FP_DEST_FIELD), .GPR_WRITE(GPR_WRITE), .FPR_WRITE(FPR_WRITE),
  .WRITE_DATA(WRITE_DATA), .FP_CAUSE_WRITE(FP_CAUSE_WRITE), .EXC_VALID(EXC_VALID), .EXC_CODE(EXC_CODE));

/* File: test/testbench.sv */
// Random testbench for the select and sign-extend unit
`include "select_unit_regs.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, c64, fpen, iv, gw, fw, cw, ev;
  logic [3:0]  rel;
  logic [2:0]  op;
  logic [1:0]  fmt, ec;
  logic [4:0]  di, wi, exp_i;
  logic [63:0] src, cnd, ft, fs, fd, wd;
  logic [68:0] exp_r;
  int          num_errors, samples_checked;

  select_sign_extend_unit select_sign_extend_unit_i (.REF_CLK(clk), .RST(rst), .ARCH_RELEASE(rel),
    .CORE_64BIT(c64), .FP_ENABLED(fpen), .ISSUE_VALID(iv), .OP_CODE(op), .FP_FMT(fmt), .DEST_INDEX(di),
    .DATA_SRC_REGISTER(src), .SECOND_GPR_FIELD(cnd), .FP_COND_FIELD(ft), .FP_DATA_FIELD(fs),
    .FP_DEST_FIELD(fd), .GPR_WRITE(gw), .FPR_WRITE(fw), .WRITE_INDEX(wi), .WRITE_DATA(wd),
    .FP_CAUSE_WRITE(cw), .EXC_VALID(ev), .EXC_CODE(ec));

  // Corner-weighted operand
  function automatic logic [63:0] pick();
    case ($urandom_range(0, 3))
      0: pick = 64'h0;
      1: pick = 64'h1 << $urandom_range(0, 63);
      2: pick = {$urandom, $urandom};
      default: pick = 64'hffff_ffff_ffff_ffff;
    endcase
  endfunction

  // Expected {gpr, fpr, exc, code, data}; reserved by default
  function automatic logic [68:0] model();
    logic [63:0] m;
    logic [63:0] c;
    m = c64 ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
    model = {5'b00101, 64'h0};
    if (op == `SU_OP_SIGN_EXT_HALF)
    begin
      if (rel >= `SU_REL_SIGN_EXT)
        model = {5'b10000, {48{src[15]}}, src[15:0]};
    end
    else if (op <= `SU_OP_FP_SEL_NEZ && rel >= `SU_REL_SELECTS)
    begin
      c = cnd & m;
      if (op[2:1] == 2'h1)
        model = {5'b10000, (op[0] ? |c : ~|c) ? src & m : 64'h0};
      else if (!fmt[1] && !fpen)
        model = {5'b00110, 64'h0};
      else if (!fmt[1])
      begin
        m = fmt[0] ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
        c = (op == `SU_OP_FP_BIT_SEL) ? (fd[0] ? ft : fs) : (ft[0] == op[0] ? fs : 64'h0);
        model = {5'b01000, c & m};
      end
    end
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(8 * 4000);
    num_errors++;
    conclude();
  end

  initial
  begin
    {rst, c64, fpen, iv, rel, op, fmt, di} = 18'h20000;
    {src, cnd, ft, fs, fd} = '0;
    exp_r = '0;
    exp_i = '0;
    void'($urandom(32'h5489a681));
    repeat (5) @(posedge clk);
    for (int i = 0; i < 3000; i++)
    begin
      @(negedge clk);
      check({gw, fw, ev}, exp_r[68:66], "write kind");
      if (exp_r[66])
        check(ec, exp_r[65:64], "exception code");
      if (exp_r[68] || exp_r[67])
        check({wi, wd}, {exp_i, exp_r[63:0]}, "result");
      check(cw, 1'b0, "cause write");
      rst = (i % 1000 == 999);
      rel = 4'($urandom_range(0, 8));
      op = (i < 8) ? i[2:0] : 3'($urandom_range(0, 7));
      {c64, fmt, di} = 8'($urandom);
      fpen = $urandom_range(0, 3) != 0;
      iv = $urandom_range(0, 5) != 0;
      {src, cnd, ft, fs, fd} = {pick(), pick(), pick(), pick(), pick()};
      exp_i = di;
      exp_r = (rst || !iv) ? 69'h0 : model();
    end
    conclude();
  end
endmodule // testbench
